//--- hdl/pwet_defines.vh
`ifndef PWET_DEFINES_VH
`define PWET_DEFINES_VH

// register indices; byte address is four times the index
`define PWET_IDX_A_RISE_HIGH 8'h41
`define PWET_IDX_A_RISE_SET 8'h42
`define PWET_IDX_A_FALL_HIGH 8'h43
`define PWET_IDX_A_FALL_SET 8'h44
`define PWET_IDX_B_RISE_HIGH 8'h45
`define PWET_IDX_B_RISE_SET 8'h46
`define PWET_IDX_CTRL 8'h50
`define PWET_IDX_PERIOD 8'h51
`define PWET_IDX_STATUS 8'h52

// fields of the edge setting registers
`define PWET_SET_LOW_MSB 7
`define PWET_SET_LOW_LSB 4
`define PWET_SET_MOD_EN 3
`define PWET_SET_MOD_DIR 2

// control register fields
`define PWET_CTRL_RUN 0

// reset values
`define PWET_RST_BYTE 8'h00
`define PWET_RST_PERIOD 12'h0C8

// timing: one edge step and the clock period, both in ns
`define PWET_TICK_NS 5
`define PWET_CLK_NS 5
`define PWET_TICK_CYCLES (`PWET_TICK_NS / `PWET_CLK_NS)

// axi responses
`define PWET_RESP_OKAY 2'h0
`define PWET_RESP_SLVERR 2'h2

`endif

//--- hdl/pwet_edge_calc.v
`timescale 1ns/1ps
`include "pwet_defines.vh"

module pwet_edge_calc (
  // clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // programmed edge and modulation
  input wire [11:0] base_time,
  input wire mod_en,
  input wire mod_dir,
  input wire [11:0] mod_amount,
  // effective edge time in ticks
  output reg [11:0] edge_time
);

  wire [12:0] sum_later;
  wire [12:0] diff_earlier;
  reg [11:0] edge_next;

  assign sum_later = {1'b0, base_time} + {1'b0, mod_amount};
  assign diff_earlier = {1'b0, base_time} - {1'b0, mod_amount};

  // move the edge by the modulation amount, clamped to the twelve-bit range 000 to FFF
  always @* begin
    if (!mod_en) begin
      edge_next = base_time;
    end else if (mod_dir) begin
      edge_next = sum_later[12] ? 12'hFFF : sum_later[11:0];
    end else begin
      edge_next = diff_earlier[12] ? 12'h000 : diff_earlier[11:0];
    end
  end

  // registered edge time
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      edge_time <= 12'h000;
    end else begin
      edge_time <= edge_next;
    end
  end

endmodule // pwet_edge_calc

//--- hdl/pwet_axil_slave.v
`timescale 1ns/1ps
`include "pwet_defines.vh"

module pwet_axil_slave (
  // clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // write address and data
  input wire [31:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  // write response
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  // read address and data
  input wire [31:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  // register side
  output reg wr_en,
  output reg [7:0] wr_idx,
  output reg [7:0] wr_byte,
  input wire wr_hit,
  output wire [7:0] rd_idx,
  input wire [31:0] rd_data,
  input wire rd_hit
);

  reg aw_held_reg;
  reg w_held_reg;
  reg [7:0] w_byte_reg;
  reg w_lane_reg;

  assign rd_idx = s_araddr[9:2];

  // ready flags are registered: high while the channel has room
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_arready <= 1'b0;
    end else begin
      s_awready <= !aw_held_reg && !(s_awvalid && s_awready) && !s_bvalid;
      s_wready <= !w_held_reg && !(s_wvalid && s_wready) && !s_bvalid;
      s_arready <= !s_rvalid && !(s_arvalid && s_arready);
    end
  end

  // write path: address and data in either order, then one response
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_idx <= 8'h00;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      wr_en <= 1'b0;
      wr_byte <= 8'h00;
      s_bvalid <= 1'b0;
      s_bresp <= `PWET_RESP_OKAY;
    end else begin
      wr_en <= 1'b0;
      if (s_awvalid && s_awready) begin
        aw_held_reg <= 1'b1;
        wr_idx <= s_awaddr[9:2];
      end
      if (s_wvalid && s_wready) begin
        w_held_reg <= 1'b1;
        w_byte_reg <= s_wdata[7:0];
        w_lane_reg <= s_wstrb[0];
      end
      if (aw_held_reg && w_held_reg && !s_bvalid) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        wr_en <= wr_hit && w_lane_reg;
        wr_byte <= w_byte_reg;
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit ? `PWET_RESP_OKAY : `PWET_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // read path: data latched at the address handshake
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `PWET_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_hit ? rd_data : 32'h00000000;
      s_rresp <= rd_hit ? `PWET_RESP_OKAY : `PWET_RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule // pwet_axil_slave

//--- hdl/pwet_top.v
// Operation
// - a rise time is high byte plus setting[7:4]
// - one time step equals 5 ns
// - a rise/fall times place output A edges
// - enable bit lets modulation move A rise
// - direction bit: 1 later, 0 earlier
// - a fall time is high byte plus setting[7:4]
// - enable bit lets modulation move A fall
// - direction bit: 1 later, 0 earlier
// - b rise time is high byte plus setting[7:4]
// - b rise time places output B rising edge
// - enable bit lets modulation move B rise
`timescale 1ns/1ps
`include "pwet_defines.vh"

module pwet_top (
  // clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // axi4-lite write address
  input wire [31:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  // axi4-lite write data
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  // axi4-lite write response
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read address
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  // axi4-lite read data
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // modulation amount from the loop filter
  input wire [11:0] MOD_AMOUNT,
  // pwm outputs to the gate drivers
  output reg PWM_OUTPUT_A,
  output reg PWM_OUTPUT_B,
  output reg PERIOD_START
);

  // prescaler end value, cut to the divider width on purpose
  localparam integer TICK_LAST_INT = `PWET_TICK_CYCLES - 1;
  localparam [3:0] TICK_LAST = TICK_LAST_INT[3:0];

  // register storage
  reg [7:0] a_rise_high_reg;
  reg [7:0] output_a_rise_setting_reg;
  reg [7:0] output_a_fall_time_high_reg;
  reg [7:0] output_a_fall_setting_reg;
  reg [7:0] output_b_rise_time_high_reg;
  reg [7:0] output_b_rise_setting_reg;
  reg run_reg;
  reg [11:0] period_reg;

  // timing state
  reg [3:0] tick_div_reg;
  reg [11:0] count_reg;
  reg [11:0] count_next;
  reg [11:0] mod_reg;
  reg pwm_a_next;
  reg pwm_b_next;

  wire wr_en;
  wire [7:0] wr_idx;
  wire [7:0] wr_byte;
  wire [7:0] rd_idx;
  reg [31:0] rd_data;
  reg rd_hit;
  wire wr_hit;
  wire tick;
  wire period_end;
  wire [11:0] a_rise_time;
  wire [11:0] a_fall_time;
  wire [11:0] b_rise_time;
  wire [11:0] a_rise_eff;
  wire [11:0] a_fall_eff;
  wire [11:0] b_rise_eff;

  // twelve-bit edge time from high byte and setting nibble
  function [11:0] edge_word;
    input [7:0] high_byte;
    input [7:0] setting;
    begin
      edge_word = {high_byte, setting[`PWET_SET_LOW_MSB:`PWET_SET_LOW_LSB]};
    end
  endfunction

  // true for an index that holds a register
  function idx_mapped;
    input [7:0] idx;
    begin
      idx_mapped = (idx >= `PWET_IDX_A_RISE_HIGH && idx <= `PWET_IDX_B_RISE_SET) ||
        (idx >= `PWET_IDX_CTRL && idx <= `PWET_IDX_STATUS);
    end
  endfunction

  assign a_rise_time = edge_word(a_rise_high_reg, output_a_rise_setting_reg);
  assign a_fall_time = edge_word(output_a_fall_time_high_reg, output_a_fall_setting_reg);
  assign b_rise_time = edge_word(output_b_rise_time_high_reg, output_b_rise_setting_reg);
  assign wr_hit = idx_mapped(wr_idx) && wr_idx != `PWET_IDX_STATUS;

  // bus slave
  pwet_axil_slave u_slave (
    .SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N),
    .s_awaddr(S_AXI_AWADDR),
    .s_awvalid(S_AXI_AWVALID),
    .s_awready(S_AXI_AWREADY),
    .s_wdata(S_AXI_WDATA),
    .s_wstrb(S_AXI_WSTRB),
    .s_wvalid(S_AXI_WVALID),
    .s_wready(S_AXI_WREADY),
    .s_bresp(S_AXI_BRESP),
    .s_bvalid(S_AXI_BVALID),
    .s_bready(S_AXI_BREADY),
    .s_araddr(S_AXI_ARADDR),
    .s_arvalid(S_AXI_ARVALID),
    .s_arready(S_AXI_ARREADY),
    .s_rdata(S_AXI_RDATA),
    .s_rresp(S_AXI_RRESP),
    .s_rvalid(S_AXI_RVALID),
    .s_rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_byte(wr_byte),
    .wr_hit(wr_hit),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // register writes; bits [1:0] of settings are stored as written
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_rise_high_reg <= `PWET_RST_BYTE;
      output_a_rise_setting_reg <= `PWET_RST_BYTE;
      output_a_fall_time_high_reg <= `PWET_RST_BYTE;
      output_a_fall_setting_reg <= `PWET_RST_BYTE;
      output_b_rise_time_high_reg <= `PWET_RST_BYTE;
      output_b_rise_setting_reg <= `PWET_RST_BYTE;
      run_reg <= 1'b0;
      period_reg <= `PWET_RST_PERIOD;
    end else if (wr_en) begin
      case (wr_idx)
        `PWET_IDX_A_RISE_HIGH: a_rise_high_reg <= wr_byte;
        `PWET_IDX_A_RISE_SET: output_a_rise_setting_reg <= wr_byte;
        `PWET_IDX_A_FALL_HIGH: output_a_fall_time_high_reg <= wr_byte;
        `PWET_IDX_A_FALL_SET: output_a_fall_setting_reg <= wr_byte;
        `PWET_IDX_B_RISE_HIGH: output_b_rise_time_high_reg <= wr_byte;
        `PWET_IDX_B_RISE_SET: output_b_rise_setting_reg <= wr_byte;
        `PWET_IDX_CTRL: run_reg <= wr_byte[`PWET_CTRL_RUN];
        `PWET_IDX_PERIOD: period_reg <= {period_reg[11:8], wr_byte};
        default: run_reg <= run_reg;
      endcase
    end
  end

  // read mux; period reads whole, status shows the period counter
  always @* begin
    rd_hit = idx_mapped(rd_idx);
    case (rd_idx)
      `PWET_IDX_A_RISE_HIGH: rd_data = {24'h000000, a_rise_high_reg};
      `PWET_IDX_A_RISE_SET: rd_data = {24'h000000, output_a_rise_setting_reg};
      `PWET_IDX_A_FALL_HIGH: rd_data = {24'h000000, output_a_fall_time_high_reg};
      `PWET_IDX_A_FALL_SET: rd_data = {24'h000000, output_a_fall_setting_reg};
      `PWET_IDX_B_RISE_HIGH: rd_data = {24'h000000, output_b_rise_time_high_reg};
      `PWET_IDX_B_RISE_SET: rd_data = {24'h000000, output_b_rise_setting_reg};
      `PWET_IDX_CTRL: rd_data = {31'h00000000, run_reg};
      `PWET_IDX_PERIOD: rd_data = {20'h00000, period_reg};
      `PWET_IDX_STATUS: rd_data = {20'h00000, count_reg};
      default: rd_data = 32'h00000000;
    endcase
  end

  // one step of the edge counter every 5 ns
  assign tick = (tick_div_reg == TICK_LAST);
  assign period_end = tick && (count_reg >= period_reg);

  always @* begin
    if (!run_reg) begin
      count_next = 12'h000;
    end else if (period_end) begin
      count_next = 12'h000;
    end else if (tick) begin
      count_next = count_reg + 12'h001;
    end else begin
      count_next = count_reg;
    end
  end

  // prescaler, counter and modulation sampled once per period
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_div_reg <= 4'h0;
      count_reg <= 12'h000;
      mod_reg <= 12'h000;
      PERIOD_START <= 1'b0;
    end else begin
      tick_div_reg <= (tick || !run_reg) ? 4'h0 : tick_div_reg + 4'h1;
      count_reg <= count_next;
      // one pulse per period: count leaves zero exactly once per period
      PERIOD_START <= run_reg && tick && (count_reg == 12'h000);
      if (!run_reg || period_end) begin
        mod_reg <= MOD_AMOUNT;
      end
    end
  end

  // effective edge times with optional modulation
  pwet_edge_calc u_a_rise (
    .SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N),
    .base_time(a_rise_time),
    .mod_en(output_a_rise_setting_reg[`PWET_SET_MOD_EN]),
    .mod_dir(output_a_rise_setting_reg[`PWET_SET_MOD_DIR]),
    .mod_amount(mod_reg),
    .edge_time(a_rise_eff)
  );

  pwet_edge_calc u_a_fall (
    .SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N),
    .base_time(a_fall_time),
    .mod_en(output_a_fall_setting_reg[`PWET_SET_MOD_EN]),
    .mod_dir(output_a_fall_setting_reg[`PWET_SET_MOD_DIR]),
    .mod_amount(mod_reg),
    .edge_time(a_fall_eff)
  );

  pwet_edge_calc u_b_rise (
    .SYS_CLK(SYS_CLK),
    .ARST_N(ARST_N),
    .base_time(b_rise_time),
    .mod_en(output_b_rise_setting_reg[`PWET_SET_MOD_EN]),
    .mod_dir(output_b_rise_setting_reg[`PWET_SET_MOD_DIR]),
    .mod_amount(mod_reg),
    .edge_time(b_rise_eff)
  );

  // output A rises at its rise time and falls at its fall time
  always @* begin
    pwm_a_next = PWM_OUTPUT_A;
    pwm_b_next = PWM_OUTPUT_B;
    if (!run_reg) begin
      pwm_a_next = 1'b0;
      pwm_b_next = 1'b0;
    end else begin
      if (count_reg == a_fall_eff) begin
        pwm_a_next = 1'b0;
      end else if (count_reg == a_rise_eff) begin
        pwm_a_next = 1'b1;
      end
      if (period_end) begin
        pwm_b_next = 1'b0;
      end else if (count_reg == b_rise_eff) begin
        pwm_b_next = 1'b1;
      end
    end
  end

  // registered pwm outputs
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PWM_OUTPUT_A <= 1'b0;
      PWM_OUTPUT_B <= 1'b0;
    end else begin
      PWM_OUTPUT_A <= pwm_a_next;
      PWM_OUTPUT_B <= pwm_b_next;
    end
  end

endmodule // pwet_top

//--- testbench/pwet_checker_asserts.sv
`timescale 1ns/1ps
module pwet_checker (
  // clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // bus handshakes
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // pwm side
  input wire PWM_OUTPUT_B,
  input wire PERIOD_START
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // address and data of a write taken at one edge
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##2 S_AXI_BVALID)
    else $error("write response late");
  rd_answer_a: assert property (rd_taken |=> S_AXI_RVALID)
    else $error("read response late");
  aw_drop_a: assert property (wr_taken |=> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("ready stayed high after handshake");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  resp_code_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0 || S_AXI_BRESP == 2'h2)
    else $error("illegal write response code");
  rdata_zero_a: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
    else $error("refused read returned data");
  pulse_gap_a: assert property (PERIOD_START |=> !PERIOD_START [*8])
    else $error("period pulse too long or too close");
  b_clear_a: assert property ($fell(PWM_OUTPUT_B) |-> ($past(PERIOD_START) || PERIOD_START) or ##1 PERIOD_START)
    else $error("output b cleared away from period end");
endmodule // pwet_checker

bind pwet_top pwet_checker pwet_checker_i (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .PWM_OUTPUT_B(PWM_OUTPUT_B), .PERIOD_START(PERIOD_START));

//--- testbench/pwet_gate_model.sv
`timescale 1ns/1ps
module pwet_gate_model (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // gate drive from the controller
  input wire period_start,
  input wire gate_a,
  input wire gate_b,
  // measured edge positions in ticks
  output reg [11:0] a_on,
  output reg [11:0] a_off,
  output reg [11:0] b_on,
  output reg [11:0] period_len
);
  reg [11:0] tick_reg;
  reg a_last;
  reg b_last;
  // ticks since period start, edges stamped as the driver sees them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= 12'h000;
      a_last <= 1'b0;
      b_last <= 1'b0;
      a_on <= 12'h000;
      a_off <= 12'h000;
      b_on <= 12'h000;
      period_len <= 12'h000;
    end else begin
      a_last <= gate_a;
      b_last <= gate_b;
      tick_reg <= period_start ? 12'h001 : tick_reg + 12'h001;
      if (period_start) period_len <= tick_reg;
      if (gate_a && !a_last) a_on <= tick_reg;
      if (!gate_a && a_last) a_off <= tick_reg;
      if (gate_b && !b_last) b_on <= tick_reg;
    end
  end
endmodule // pwet_gate_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`include "pwet_defines.vh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, seed = 32'd6408;
  logic [3:0] wstrb = 4'hF;
  logic [11:0] mod = 12'h000;
  wire awready, wready, bvalid, arready, rvalid, out_a, out_b, pstart;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [11:0] a_on, a_off, b_on, plen;
  int failures = 0, cmp_count = 0, cycles = 0;
  always #2.5 clk = ~clk;
  pwet_top pwet_top_i (.SYS_CLK(clk), .ARST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .MOD_AMOUNT(mod), .PWM_OUTPUT_A(out_a), .PWM_OUTPUT_B(out_b),
    .PERIOD_START(pstart));
  pwet_gate_model pwet_gate_model_i (.clk(clk), .rst_n(rst_n), .period_start(pstart),
    .gate_a(out_a), .gate_b(out_b), .a_on(a_on), .a_off(a_off), .b_on(b_on), .period_len(plen));
  // repeatable random source
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected edge: 12-bit time, moved by modulation when enabled
  function automatic logic [11:0] eff(input logic [7:0] hi, input logic [7:0] st,
                                      input logic [11:0] m);
    logic [11:0] b;
    b = {hi, st[7:4]};
    if (!st[3]) return b;
    return st[2] ? b + m : b - m;
  endfunction
  // one write; address and data offered together
  task automatic axw(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (!bvalid) failures++;
    r = bresp;
    bready <= 1'b0;
  endtask
  // one read
  task automatic axr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (!rvalid) failures++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // wait for a number of period starts
  task automatic wait_starts(input int cnt);
    int k;
    repeat (cnt) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (!pstart && k < 600);
      if (!pstart) failures++;
    end
    // let the model's stamps settle before they are read
    @(negedge clk);
  endtask
  task report_and_stop;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // cycle ceiling for a hung run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      report_and_stop;
    end
  end
  // main sequence
  initial begin
    logic [1:0] r;
    logic [31:0] d, x;
    logic [7:0] sa, sf, sb, v0;
    logic [11:0] m, ar, af, br;
    int i;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) begin
      axr(8'h41 + 8'(i), d, r);
      `CHK("reset value", 32'h0, d)
    end
    axr(`PWET_IDX_PERIOD, d, r);
    `CHK("period reset", 32'h0C8, d)
    axr(8'h60, d, r);
    `CHK("unmapped read", `PWET_RESP_SLVERR, r)
    axw(`PWET_IDX_STATUS, 8'h01, r);
    `CHK("status write", `PWET_RESP_SLVERR, r)
    for (i = 0; i < 6; i++) begin
      x = xorshift();
      axw(8'h41 + 8'(i), x[7:0] & 8'hFC, r);
      axr(8'h41 + 8'(i), d, r);
      `CHK("readback", {24'h0, x[7:0] & 8'hFC}, d)
      if (i == 0) v0 = x[7:0] & 8'hFC;
    end
    wstrb <= 4'hE;
    axw(`PWET_IDX_A_RISE_HIGH, 8'h5B, r);
    wstrb <= 4'hF;
    axr(`PWET_IDX_A_RISE_HIGH, d, r);
    `CHK("masked write", {24'h0, v0}, d)
    axw(`PWET_IDX_CTRL, 8'h01, r);
    wait_starts(2);
    `CHK("period length", 12'h0C9, plen)
    for (i = 0; i < 14; i++) begin
      x = xorshift();
      sa = {x[3:0], x[4], x[5], 2'b00};
      sf = {x[9:6], x[10], x[11], 2'b00};
      sb = {x[15:12], x[16], x[17], 2'b00};
      m = {8'h0, x[23:20]};
      if (i == 0) begin
        sa = 8'hFC;
        sf = 8'hF8;
        sb = 8'hFC;
        m = 12'h00F;
      end
      axw(`PWET_IDX_A_RISE_HIGH, 8'h02, r);
      axw(`PWET_IDX_A_RISE_SET, sa, r);
      axw(`PWET_IDX_A_FALL_HIGH, 8'h08, r);
      axw(`PWET_IDX_A_FALL_SET, sf, r);
      axw(`PWET_IDX_B_RISE_HIGH, 8'h05, r);
      axw(`PWET_IDX_B_RISE_SET, sb, r);
      mod <= m;
      wait_starts(3);
      ar = eff(8'h02, sa, m);
      af = eff(8'h08, sf, m);
      br = eff(8'h05, sb, m);
      `CHK("a high width", af - ar, a_off - a_on)
      `CHK("b rise offset", br - ar, b_on - a_on)
    end
    report_and_stop;
  end
endmodule // tb_top
